// ===== src/adc_digital_output_control.sv
// Converter digital output stage with serial register port
// Summary of operation
// - Eight lane_invert bits at lane_polarity invert each LVDS data lane individually.
// - Bit at 0x68 inverts the word strobe / overrange pair.
// - Separate bit at 0x68 inverts the auxiliary data pair.
// - Three-bit driver_current_sel at 0x63, default 3.5 mA.
// - Load-enable bit at 0x63 switches on internal 100 ohm termination.
// - Register 0x02 lowers output data and clock rate together.
// - Full-rate CMOS data changes on rising output clock edge.
// - DDR LVDS data changes on both output clock edges.
// - In delay-locked timing, phase delay applies only when clock_phase_en at clock_phase_enable is one.
// - Delay-locked timing without decimation takes delay from dll_clock_phase.
// - With decimation, delay comes from the decimated phase field.
// - Phase-locked timing takes output clock delay from pll_clock_delay.
// - Randomizer at 0x07 XORs the LSB into every other data bit.
// - Randomizer leaves clock, flag, strobe, aux bits and LSB alone.
// - Output mode 00 at 0x62 disables every digital output.
// - Three-bit test field at 0x62; user patterns from 0x74 to 0x77.
// - In test mode outputs carry only the pattern, never conversions.
// - Test field 111 outputs 16-bit LFSR, 1+x^4+x^13+x^15+x^16.
// - 16-bit mode: all bits out; 15,14 to flag/strobe; 1,0 to aux.
// - 14-bit mode: bits 15..2 on data 13..0; 15,14 to flag/strobe.
// - CMOS pattern drives all pins; LVDS pattern only enabled pairs.
// - DDR strobe goes on rising edge, overrange on falling, one pair.
`timescale 1ns/100ps
module adc_digital_output_control
  import adc_out_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int LANES  = 8
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              spi_sclk,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output      logic              spi_miso,
  output      logic              spi_miso_oe,
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic              sample_overrange,
  input  wire logic              sample_strobe,
  input  wire logic              sample_aux_one,
  input  wire logic              sample_aux_two,
  input  wire logic              timing_pll,
  input  wire logic              decim_active,
  output      logic              output_clock,
  output      logic              output_clock_oe,
  output      logic [DATA_W-1:0] data_outputs,
  output      logic              overrange_flag,
  output      logic              word_strobe,
  output      logic              aux_bit_one,
  output      logic              aux_bit_two,
  output      logic              cmos_oe,
  output      logic [LANES-1:0]  lvds_lane,
  output      logic [LANES-1:0]  lvds_lane_oe,
  output      logic              lvds_strobe_flag,
  output      logic              lvds_aux,
  output      logic              lvds_oe,
  output      logic [2:0]        driver_current_sel,
  output      logic              termination_en
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] sclk_sync;
  logic [2:0] cs_sync;
  logic [2:0] mosi_sync;
  logic       sclk_lvl;
  logic       cs_n_lvl;
  logic       mosi_lvl;

  function automatic logic settle(input logic [2:0] s, input logic cur);
    settle = (s[1] == s[2]) ? s[2] : cur;
  endfunction : settle

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync <= 3'h0;
      cs_sync   <= 3'h7;
      mosi_sync <= 3'h0;
      sclk_lvl  <= 1'b0;
      cs_n_lvl  <= 1'b1;
      mosi_lvl  <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], spi_sclk};
      cs_sync   <= {cs_sync[1:0], spi_cs_n};
      mosi_sync <= {mosi_sync[1:0], spi_mosi};
      sclk_lvl  <= settle(sclk_sync, sclk_lvl);
      cs_n_lvl  <= settle(cs_sync, cs_n_lvl);
      mosi_lvl  <= settle(mosi_sync, mosi_lvl);
    end
  end

  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_lvl;
    end
  end

  assign sclk_rise = !cs_n_lvl && sclk_lvl && !sclk_prev;
  assign sclk_fall = !cs_n_lvl && !sclk_lvl && sclk_prev;

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame: read flag, seven address bits, eight data bits
  logic [4:0]  bit_cnt;
  logic [14:0] in_shift;
  logic [7:0]  out_shift;
  logic        wr_stb;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt  <= 5'h0;
      in_shift <= 15'h0;
      wr_stb   <= 1'b0;
      wr_addr  <= 7'h0;
      wr_data  <= 8'h0;
    end else begin
      wr_stb <= 1'b0;
      if (cs_n_lvl) begin
        bit_cnt <= 5'h0;
      end else if (sclk_rise && bit_cnt != SPI_LAST_BIT) begin
        bit_cnt  <= bit_cnt + 5'h1;
        in_shift <= {in_shift[13:0], mosi_lvl};
        if (bit_cnt == SPI_LAST_BIT - 5'h1 && !in_shift[14]) begin
          wr_stb  <= 1'b1;
          wr_addr <= in_shift[13:7];
          wr_data <= {in_shift[6:0], mosi_lvl};
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift   <= 8'h0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= !cs_n_lvl;
      spi_miso    <= out_shift[7];
      if (sclk_rise && bit_cnt == SPI_ADDR_BITS - 5'h1) begin
        out_shift <= rd_data;
      end else if (sclk_fall && bit_cnt > SPI_ADDR_BITS) begin
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] output_rate_control;
  logic [7:0] output_misc_control;
  logic [7:0] dll_clock_phase;
  logic [7:0] output_mode_select;
  logic [7:0] lvds_driver_control;
  logic [7:0] clock_phase_enable;
  logic [7:0] lane_polarity;
  logic [7:0] strobe_flag_control;
  logic [7:0] pll_clock_delay;
  logic [7:0] user_pattern_0;
  logic [7:0] user_pattern_1;
  logic [7:0] user_pattern_2;
  logic [7:0] user_pattern_3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_rate_control <= RST_ZERO;
      output_misc_control <= RST_ZERO;
      dll_clock_phase     <= RST_ZERO;
      output_mode_select  <= RST_MODE;
      lvds_driver_control <= RST_DRIVER;
      clock_phase_enable  <= RST_ZERO;
      lane_polarity       <= RST_ZERO;
      strobe_flag_control <= RST_ZERO;
      pll_clock_delay     <= RST_ZERO;
      user_pattern_0      <= RST_ZERO;
      user_pattern_1      <= RST_ZERO;
      user_pattern_2      <= RST_ZERO;
      user_pattern_3      <= RST_ZERO;
    end else if (wr_stb) begin
      unique case (wr_addr)
        OFS_RATE:    output_rate_control <= wr_data;
        OFS_MISC:    output_misc_control <= wr_data;
        OFS_DLL:     dll_clock_phase     <= wr_data;
        OFS_MODE:    output_mode_select  <= wr_data;
        OFS_DRIVER:  lvds_driver_control <= wr_data;
        OFS_PHASE:   clock_phase_enable  <= wr_data;
        OFS_LANEPOL: lane_polarity       <= wr_data;
        OFS_STROBE:  strobe_flag_control <= wr_data;
        OFS_PLL:     pll_clock_delay     <= wr_data;
        OFS_USER0:   user_pattern_0      <= wr_data;
        OFS_USER1:   user_pattern_1      <= wr_data;
        OFS_USER2:   user_pattern_2      <= wr_data;
        OFS_USER3:   user_pattern_3      <= wr_data;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case ({in_shift[5:0], mosi_lvl})
      OFS_RATE:    rd_data = output_rate_control;
      OFS_MISC:    rd_data = output_misc_control;
      OFS_DLL:     rd_data = dll_clock_phase;
      OFS_MODE:    rd_data = output_mode_select;
      OFS_DRIVER:  rd_data = lvds_driver_control;
      OFS_PHASE:   rd_data = clock_phase_enable;
      OFS_LANEPOL: rd_data = lane_polarity;
      OFS_STROBE:  rd_data = strobe_flag_control;
      OFS_PLL:     rd_data = pll_clock_delay;
      OFS_USER0:   rd_data = user_pattern_0;
      OFS_USER1:   rd_data = user_pattern_1;
      OFS_USER2:   rd_data = user_pattern_2;
      OFS_USER3:   rd_data = user_pattern_3;
      default:     rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driver_current_sel <= RST_DRIVER[DRV_HI:DRV_LO];
      termination_en     <= 1'b0;
    end else begin
      driver_current_sel <= lvds_driver_control[DRV_HI:DRV_LO];
      termination_en     <= lvds_driver_control[DRV_LOAD];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded controls
  logic [1:0] out_mode;
  logic [2:0] test_sel;
  logic       res14;
  logic       is_cmos;
  logic       is_off;
  logic [2:0] phase_sel;

  assign out_mode = output_mode_select[MODE_HI:MODE_LO];
  assign test_sel = output_mode_select[TEST_HI:TEST_LO];
  assign res14    = output_mode_select[MODE_RES14];
  assign is_off   = (out_mode == OMODE_OFF);
  assign is_cmos  = (out_mode == OMODE_CMOS);

  always_comb begin
    if (timing_pll) begin
      phase_sel = pll_clock_delay[DLY_HI:DLY_LO];
    end else if (!clock_phase_enable[PH_EN]) begin
      phase_sel = 3'h0;
    end else if (decim_active) begin
      phase_sel = clock_phase_enable[PH_DEC_HI:PH_DEC_LO];
    end else begin
      phase_sel = dll_clock_phase[DLY_HI:DLY_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output clock generation with rate reduction and phase delay
  logic [7:0] div_cnt;
  logic [7:0] div_limit;
  logic       raw_clk;
  logic       tick;
  logic       next_raw;
  logic [6:0] clk_dly;

  assign div_limit = (8'h01 << output_rate_control[RATE_HI:RATE_LO]) - 8'h01;
  assign tick      = (div_cnt == div_limit);
  assign next_raw  = tick ? !raw_clk : raw_clk;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h0;
      raw_clk <= 1'b0;
      clk_dly <= 7'h0;
    end else begin
      div_cnt <= tick ? 8'h0 : div_cnt + 8'h1;
      raw_clk <= next_raw;
      clk_dly <= {clk_dly[5:0], next_raw};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_clock    <= 1'b0;
      output_clock_oe <= 1'b0;
    end else begin
      output_clock_oe <= !is_off;
      if (is_off) begin
        output_clock <= 1'b0;
      end else if (phase_sel == 3'h0) begin
        output_clock <= next_raw;
      end else begin
        output_clock <= clk_dly[phase_sel - 3'h1];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Word assembly: conversion data or test pattern
  logic              word_load;
  logic [15:0]       prbs_word;
  logic              user_phase;
  logic [DATA_W-1:0] next_data;
  logic              next_ovr;
  logic              next_wck;
  logic              next_aux1;
  logic              next_aux2;

  assign word_load = tick && !raw_clk;

  function automatic logic [15:0] lfsr_step(input logic [15:0] p);
    lfsr_step = {p[14:0], p[15] ^ p[14] ^ p[12] ^ p[3]};
  endfunction : lfsr_step

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prbs_word   <= PRBS_SEED;
      user_phase  <= 1'b0;
    end else begin
      if (test_sel != TP_PRBS) begin
        prbs_word <= PRBS_SEED;
      end else if (word_load) begin
        prbs_word <= lfsr_step(prbs_word);
      end
      if (word_load) begin
        user_phase <= !user_phase;
      end
    end
  end

  always_comb begin
    next_data = '0;
    next_ovr  = 1'b0;
    next_wck  = 1'b0;
    next_aux1 = 1'b0;
    next_aux2 = 1'b0;
    unique case (test_sel)
      TP_NORMAL: begin
        next_data = sample_data;
        if (output_misc_control[MISC_RANDOM]) begin
          next_data[DATA_W-1:1] = sample_data[DATA_W-1:1]
                                ^ {(DATA_W-1){sample_data[0]}};
        end
        if (res14) begin
          next_data[DATA_W-1:DATA_W-2] = 2'b00;
        end
        next_ovr  = sample_overrange;
        next_wck  = sample_strobe;
        next_aux1 = sample_aux_one;
        next_aux2 = sample_aux_two;
      end
      TP_ZEROS:  next_data = '0;
      TP_ONES:   next_data = '1;
      TP_ALT:    next_data = ALT_WORD[DATA_W-1:0];
      TP_USERA:  next_data = {user_pattern_1, user_pattern_0};
      TP_USERB:  next_data = {user_pattern_3, user_pattern_2};
      TP_TOGGLE: begin
        next_data = user_phase ? {user_pattern_3, user_pattern_2}
                               : {user_pattern_1, user_pattern_0};
      end
      TP_PRBS: begin
        next_ovr = prbs_word[15];
        next_wck = prbs_word[14];
        if (res14) begin
          next_data = {2'b00, prbs_word[15:2]};
        end else begin
          next_data = prbs_word;
          next_aux1 = prbs_word[1];
          next_aux2 = prbs_word[0];
        end
      end
    endcase
    if (res14 && test_sel != TP_NORMAL) begin
      next_data[DATA_W-1:DATA_W-2] = 2'b00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output pins
  logic [DATA_W-1:0] word_data;
  logic              word_ovr;
  logic              word_wck;
  logic              word_aux1;
  logic              word_aux2;
  logic [LANES-1:0]  lane_en;
  logic [LANES-1:0]  even_bits;
  logic [LANES-1:0]  odd_bits;

  assign lane_en = res14 ? {1'b0, {(LANES-1){1'b1}}} : '1;

  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      even_bits[i] = next_data[2*i];
      odd_bits[i]  = word_data[2*i+1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_data <= '0;
      word_ovr  <= 1'b0;
      word_wck  <= 1'b0;
      word_aux1 <= 1'b0;
      word_aux2 <= 1'b0;
    end else if (word_load) begin
      word_data <= next_data;
      word_ovr  <= next_ovr;
      word_wck  <= next_wck;
      word_aux1 <= next_aux1;
      word_aux2 <= next_aux2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_outputs   <= '0;
      overrange_flag <= 1'b0;
      word_strobe    <= 1'b0;
      aux_bit_one    <= 1'b0;
      aux_bit_two    <= 1'b0;
      cmos_oe        <= 1'b0;
    end else begin
      cmos_oe <= is_cmos;
      if (!is_cmos) begin
        data_outputs   <= '0;
        overrange_flag <= 1'b0;
        word_strobe    <= 1'b0;
        aux_bit_one    <= 1'b0;
        aux_bit_two    <= 1'b0;
      end else if (word_load) begin
        data_outputs   <= next_data;
        overrange_flag <= next_ovr;
        word_strobe    <= next_wck;
        aux_bit_one    <= next_aux1;
        aux_bit_two    <= next_aux2;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvds_lane        <= '0;
      lvds_lane_oe     <= '0;
      lvds_strobe_flag <= 1'b0;
      lvds_aux         <= 1'b0;
      lvds_oe          <= 1'b0;
    end else begin
      lvds_oe      <= !is_off && !is_cmos;
      lvds_lane_oe <= (!is_off && !is_cmos) ? lane_en : '0;
      if (is_off || is_cmos) begin
        lvds_lane        <= '0;
        lvds_strobe_flag <= 1'b0;
        lvds_aux         <= 1'b0;
      end else if (tick && !raw_clk) begin
        lvds_lane        <= (even_bits ^ lane_polarity) & lane_en;
        lvds_strobe_flag <= next_wck ^ strobe_flag_control[STB_INV];
        lvds_aux         <= next_aux1 ^ strobe_flag_control[AUX_INV];
      end else if (tick) begin
        lvds_lane        <= (odd_bits ^ lane_polarity) & lane_en;
        lvds_strobe_flag <= word_ovr ^ strobe_flag_control[STB_INV];
        lvds_aux         <= word_aux2 ^ strobe_flag_control[AUX_INV];
      end
    end
  end

endmodule : adc_digital_output_control

// ===== src/adc_out_pkg.sv
// Constants for the converter digital output stage
package adc_out_pkg;
  // Register offsets
  localparam logic [6:0] OFS_RATE    = 7'h02;
  localparam logic [6:0] OFS_MISC    = 7'h07;
  localparam logic [6:0] OFS_DLL     = 7'h52;
  localparam logic [6:0] OFS_MODE    = 7'h62;
  localparam logic [6:0] OFS_DRIVER  = 7'h63;
  localparam logic [6:0] OFS_PHASE   = 7'h64;
  localparam logic [6:0] OFS_LANEPOL = 7'h65;
  localparam logic [6:0] OFS_STROBE  = 7'h68;
  localparam logic [6:0] OFS_PLL     = 7'h6d;
  localparam logic [6:0] OFS_USER0   = 7'h74;
  localparam logic [6:0] OFS_USER1   = 7'h75;
  localparam logic [6:0] OFS_USER2   = 7'h76;
  localparam logic [6:0] OFS_USER3   = 7'h77;
  // Reset values
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h02;
  localparam logic [7:0] RST_DRIVER  = 8'h00;
  // Field positions
  localparam int RATE_LO      = 0;
  localparam int RATE_HI      = 2;
  localparam int MISC_RANDOM  = 0;
  localparam int MODE_LO      = 0;
  localparam int MODE_HI      = 1;
  localparam int TEST_LO      = 2;
  localparam int TEST_HI      = 4;
  localparam int MODE_RES14   = 5;
  localparam int DRV_LO       = 0;
  localparam int DRV_HI       = 2;
  localparam int DRV_LOAD     = 3;
  localparam int PH_EN        = 0;
  localparam int PH_DEC_LO    = 1;
  localparam int PH_DEC_HI    = 3;
  localparam int DLY_LO       = 0;
  localparam int DLY_HI       = 2;
  localparam int STB_INV      = 0;
  localparam int AUX_INV      = 1;
  // Output modes
  localparam logic [1:0] OMODE_OFF  = 2'h0;
  localparam logic [1:0] OMODE_CMOS = 2'h1;
  // Test patterns
  localparam logic [2:0] TP_NORMAL = 3'h0;
  localparam logic [2:0] TP_ZEROS  = 3'h1;
  localparam logic [2:0] TP_ONES   = 3'h2;
  localparam logic [2:0] TP_ALT    = 3'h3;
  localparam logic [2:0] TP_USERA  = 3'h4;
  localparam logic [2:0] TP_USERB  = 3'h5;
  localparam logic [2:0] TP_TOGGLE = 3'h6;
  localparam logic [2:0] TP_PRBS   = 3'h7;
  localparam logic [15:0] ALT_WORD  = 16'haaaa;
  localparam logic [15:0] PRBS_SEED = 16'h0001;
  // Serial port framing
  localparam logic [4:0] SPI_ADDR_BITS = 5'h08;
  localparam logic [4:0] SPI_LAST_BIT  = 5'h10;
endpackage : adc_out_pkg

// ===== tb/adc_out_props.sv
// Port checker for the converter output stage
`timescale 1ns/100ps
module adc_out_props #(
  parameter int DATA_W = 16,
  parameter int LANES  = 8
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              spi_cs_n,
  input wire logic              spi_miso_oe,
  input wire logic              output_clock,
  input wire logic              output_clock_oe,
  input wire logic [DATA_W-1:0] data_outputs,
  input wire logic              overrange_flag,
  input wire logic              word_strobe,
  input wire logic              aux_bit_one,
  input wire logic              aux_bit_two,
  input wire logic              cmos_oe,
  input wire logic [LANES-1:0]  lvds_lane,
  input wire logic [LANES-1:0]  lvds_lane_oe,
  input wire logic              lvds_strobe_flag,
  input wire logic              lvds_aux,
  input wire logic              lvds_oe,
  input wire logic [2:0]        driver_current_sel,
  input wire logic              termination_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_mode_exclusive: assert property (
    !(cmos_oe && lvds_oe)) else $error("both output modes on");
  a_clock_enable: assert property (
    cmos_oe || lvds_oe |-> output_clock_oe) else $error("clock off in active mode");
  a_off_quiet: assert property (
    !output_clock_oe |-> !output_clock && !cmos_oe && !lvds_oe) else $error("off mode active");
  a_cmos_idle: assert property (
    !cmos_oe |-> data_outputs == '0 && !overrange_flag && !word_strobe
      && !aux_bit_one && !aux_bit_two) else $error("cmos pins driven");
  a_lvds_idle: assert property (
    !lvds_oe |-> lvds_lane == '0 && lvds_lane_oe == '0 && !lvds_strobe_flag
      && !lvds_aux) else $error("lvds pairs driven");
  a_current_hold: assert property (
    spi_cs_n [*8] |=> $stable(driver_current_sel)) else $error("current changed");
  a_term_hold: assert property (
    spi_cs_n [*8] ##1 spi_cs_n |-> termination_en == $past(termination_en))
    else $error("termination changed");
  a_lane_hold: assert property (
    spi_cs_n [*8] |=> $stable(lvds_lane_oe)) else $error("lane enables changed");
  a_miso_release: assert property (
    spi_cs_n [*8] |-> !spi_miso_oe) else $error("serial output driven while deselected");
endmodule : adc_out_props

bind adc_digital_output_control adc_out_props #(.DATA_W(DATA_W), .LANES(LANES))
  props (.*);

// ===== tb/host_receiver.sv
// Host receiver model latching CMOS words on the falling output clock
`timescale 1ns/100ps
module host_receiver (
  input  wire logic        clk,
  input  wire logic        output_clock,
  input  wire logic [15:0] data_outputs,
  input  wire logic [3:0]  flags,
  input  wire logic        descramble,
  output      logic        rx_valid,
  output      logic [19:0] rx_word
);
  logic        prev_clock;
  logic [15:0] word;
  always_comb word = descramble ? data_outputs ^ {{15{data_outputs[0]}}, 1'b0}
                                : data_outputs;
  always @(posedge clk) begin
    prev_clock <= output_clock;
    rx_valid   <= prev_clock && !output_clock;
    rx_word    <= {flags, word};
  end
endmodule : host_receiver

// ===== tb/testbench.sv
// Self-checking bench for the converter output stage
`timescale 1ns/100ps
module testbench;
  import adc_out_pkg::*;
  logic        clk, rst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, output_clock;
  logic        sample_overrange, sample_strobe, sample_aux_one, sample_aux_two;
  logic        timing_pll, decim_active, termination_en, descramble, rx_valid, rd_ready;
  logic        overrange_flag, word_strobe, aux_bit_one, aux_bit_two, lvds_strobe_flag, lvds_aux;
  logic [15:0] sample_data, data_outputs, lfsr, skip, p;
  logic [15:0] pat[4];
  logic [7:0]  lvds_lane, rd;
  logic [7:0]  vals[12];
  logic [2:0]  driver_current_sel;
  logic [19:0] rx_word, mask;
  logic [19:0] word_q[$];
  logic [7:0]  reg_q[$];
  logic [6:0]  ofs[12] = '{OFS_RATE, OFS_MISC, OFS_DLL, OFS_DRIVER, OFS_PHASE, OFS_LANEPOL,
                           OFS_STROBE, OFS_PLL, OFS_USER0, OFS_USER1, OFS_USER2, OFS_USER3};
  int          bad_count, comparisons, n;

  adc_digital_output_control dut (.clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe(), .sample_data, .sample_overrange, .sample_strobe, .sample_aux_one,
    .sample_aux_two, .timing_pll, .decim_active, .output_clock, .output_clock_oe(),
    .data_outputs, .overrange_flag, .word_strobe, .aux_bit_one, .aux_bit_two, .cmos_oe(),
    .lvds_lane, .lvds_lane_oe(), .lvds_strobe_flag, .lvds_aux, .lvds_oe(),
    .driver_current_sel, .termination_en);
  host_receiver host (.clk, .output_clock, .data_outputs, .descramble, .rx_valid, .rx_word,
    .flags({overrange_flag, word_strobe, aux_bit_one, aux_bit_two}));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] pn(input logic [15:0] v);
    pn = {v[14:0], v[15] ^ v[14] ^ v[12] ^ v[3]};
  endfunction : pn

  task automatic wait_clk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : wait_clk

  task automatic check(input string what, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic test_done;
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // One serial frame, first bit read/write, then address and data
  task automatic frame(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] bits;
    bits = {rw, a, d};
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = bits[i];
      wait_clk(8);
      if (i < 8) rd[i] = spi_miso;
      spi_sclk = 1'b1;
      wait_clk(8);
      spi_sclk = 1'b0;
    end
    wait_clk(8);
    spi_cs_n = 1'b1;
    wait_clk(8);
  endtask : frame

  task automatic note(input logic [7:0] e, input logic [7:0] g);
    reg_q.push_back(e);
    rd = g;
    rd_ready = 1'b1;
    wait_clk(1);
    rd_ready = 1'b0;
    wait_clk(1);
  endtask : note

  task automatic rd_reg(input logic [6:0] a, input logic [7:0] e);
    frame(1'b1, a, 8'h00);
    note(e, rd);
  endtask : rd_reg

  task automatic drain;
    for (n = 0; n < 4000 && word_q.size() > 0; n++) wait_clk(1);
    if (word_q.size() > 0) begin
      bad_count++;
      test_done();
    end
  endtask : drain

  // Park on a known pattern, then switch to the one under test
  task automatic show(input logic [2:0] pre, input logic [7:0] m, input logic [19:0] e);
    frame(1'b0, OFS_MODE, {m[7:5], pre, m[1:0]});
    repeat (4) word_q.push_back(e);
    frame(1'b0, OFS_MODE, m);
    drain();
  endtask : show

  always @(posedge clk) if (rd_ready === 1'b1) check("register", reg_q.pop_front(), rd);
  always @(posedge clk)
    if (rx_valid === 1'b1 && word_q.size() > 0 && rx_word[15:0] !== skip)
      check("word", word_q.pop_front() & mask, rx_word & mask);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, spi_sclk, spi_mosi, descramble, timing_pll, decim_active, rd_ready} = '0;
    {sample_overrange, sample_strobe, sample_aux_one, sample_aux_two} = 4'h0;
    {spi_cs_n, sample_data, lfsr, skip, mask} = {1'b1, 16'h0, 16'hb4ce, 16'h0, 20'hfffff};
    {bad_count, comparisons} = '0;
    wait_clk(4);
    rst_n = 1'b1;
    wait_clk(4);
    rd_reg(OFS_MODE, RST_MODE);
    rd_reg(OFS_DRIVER, RST_DRIVER);
    foreach (ofs[i]) begin
      lfsr = pn(lfsr);
      vals[i] = lfsr[7:0];
      frame(1'b0, ofs[i], vals[i]);
      rd_reg(ofs[i], vals[i]);
    end
    note({4'h0, vals[3][3:0]}, {4'h0, termination_en, driver_current_sel});
    frame(1'b0, 7'h10, 8'hff);
    rd_reg(7'h10, 8'h00);
    for (int i = 0; i < 8; i++) frame(1'b0, ofs[i], 8'h00);
    frame(1'b0, OFS_RATE, 8'h02);
    for (n = 0; n < 64 && output_clock !== 1'b0; n++) wait_clk(1);
    for (n = 0; n < 64 && output_clock !== 1'b1; n++) wait_clk(1);
    for (n = 0; n < 64 && output_clock === 1'b1; n++) wait_clk(1);
    note(8'h04, n[7:0]);
    frame(1'b0, OFS_RATE, 8'h00);
    lfsr = pn(lfsr);
    sample_data = lfsr | 16'h0001;
    {sample_overrange, sample_strobe, sample_aux_one, sample_aux_two} = 4'hb;
    frame(1'b0, OFS_MISC, 8'h01);
    descramble = 1'b1;
    show(TP_ZEROS, {3'h0, TP_NORMAL, OMODE_CMOS}, {4'hb, sample_data});
    descramble = 1'b0;
    frame(1'b0, OFS_MISC, 8'h00);
    mask = 20'h0ffff;
    pat = '{16'hffff, ALT_WORD, {vals[9], vals[8]}, {vals[11], vals[10]}};
    for (int t = 0; t < 4; t++)
      show(TP_ZEROS, {3'h0, 3'(t + 2), OMODE_CMOS}, {4'h0, pat[t]});
    skip = 16'hffff;
    show(TP_ONES, {3'h0, TP_ZEROS, OMODE_CMOS}, 20'h0);
    skip = 16'h0000;
    frame(1'b0, OFS_MODE, {3'h0, TP_TOGGLE, OMODE_CMOS});
    for (int r = 0; r < 2; r++) begin
      mask = (r != 0) ? 20'hcffff : 20'hfffff;
      frame(1'b0, OFS_MODE, {2'h0, r[0], TP_ZEROS, OMODE_CMOS});
      p = PRBS_SEED;
      if (r != 0) p = pn(pn(p));
      for (int i = 0; i < 6; i++) begin
        word_q.push_back((r != 0) ? {p[15:14], 4'h0, p[15:2]} : {p[15:14], p[1:0], p});
        p = pn(p);
      end
      frame(1'b0, OFS_MODE, {2'h0, r[0], TP_PRBS, OMODE_CMOS});
      drain();
    end
    frame(1'b0, OFS_LANEPOL, 8'ha5);
    frame(1'b0, OFS_STROBE, 8'h03);
    frame(1'b0, OFS_MODE, {3'h0, TP_ALT, 2'h2});
    for (n = 0; n < 64 && output_clock !== 1'b1; n++) wait_clk(1);
    note(8'ha5, lvds_lane);
    for (n = 0; n < 64 && output_clock !== 1'b0; n++) wait_clk(1);
    p = {6'h0, lvds_strobe_flag, lvds_aux, lvds_lane};
    note(8'h5a, p[7:0]);
    note(8'h03, {6'h0, p[9:8]});
    frame(1'b0, OFS_DLL, 8'h01);
    frame(1'b0, OFS_PHASE, 8'h01);
    for (int k = 0; k < 3; k++) begin
      {timing_pll, decim_active} = 2'(k);
      wait_clk(2);
      for (n = 0; n < 64 && output_clock !== 1'b1; n++) wait_clk(1);
      note((k == 0) ? 8'h5a : 8'ha5, lvds_lane);
    end
    frame(1'b0, OFS_MODE, 8'h00);
    wait_clk(8);
    test_done();
  end
endmodule : testbench
